// ---- hw/sfrs_top.sv ----
// supply-fail reset sequencer: state machine, monitor filter and apb registers
`default_nettype none
module sfrs_top #(
    parameter int unsigned OSC_SETTLE_US = sfrs_pkg::OSC_SETTLE_US_DFLT
) (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        por_ok_i,
    input  wire logic        rst_ok_i,
    input  wire logic        warn_ok_i,
    input  wire logic        ring_clk_i,
    input  wire logic        ext_rst_i,
    input  wire logic        stop_req_i,
    input  wire logic        wake_irq_i,
    input  wire logic [3:0]  wake_prio_i,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             cpu_rst_o,
    output logic             reg_en_o,
    output logic             osc_en_o,
    output logic             mon_en_o,
    output logic             sram_ret_o,
    output logic             stop_exit_o,
    output logic             take_warn_o,
    output logic             supply_warn_irq_flag_o,
    output logic [15:0]      boot_addr_o
);
    localparam logic [23:0] SETTLE_CYC = 24'(OSC_SETTLE_US * sfrs_pkg::CLK_MHZ);

    function automatic logic [23:0] ivl_ticks(input logic [1:0] sel);
        unique case (sel)
            2'h0: ivl_ticks = sfrs_pkg::IVL_CONT;
            2'h1: ivl_ticks = sfrs_pkg::IVL_2E11;
            2'h2: ivl_ticks = sfrs_pkg::IVL_2E12;
            2'h3: ivl_ticks = sfrs_pkg::IVL_2E13;
        endcase
    endfunction

    sfrs_pkg::sfrs_state_e state_q, state_d;
    logic [3:0]  sync_s;
    logic        por_ok_s, rst_ok_s, warn_ok_s, ring_s, ring_d1_q, ring_tick;
    logic [1:0]  rst_lo_q, warn_lo_q, chk_cnt_q;
    logic        chk_win_q, rst_fail, warn_fail;
    logic        monoff_q, wake_q, wake_exit_q, pf_boot_q, stop_exit_q, take_warn_q;
    logic [1:0]  ivl_q;
    logic [3:0]  warn_prio_q, wake_prio_q;
    logic        warn_flag_q, pfr_flag_q, warn_set, pfr_set;
    logic [15:0] boot_q;
    logic        tmr_load, tmr_tick, tmr_zero, enter;
    logic [23:0] tmr_val;
    logic [31:0] prdata_q;
    logic        apb_wr, ctrl_hit, stat_hit;

    // comparators are asynchronous analog levels
    sfrs_sync #(.W(4)) u_sync (
        .clk_i (clk_i),
        .srst_i(srst_i),
        .d_i   ({ring_clk_i, warn_ok_i, rst_ok_i, por_ok_i}),
        .q_o   (sync_s)
    );
    assign {ring_s, warn_ok_s, rst_ok_s, por_ok_s} = sync_s;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ring_d1_q <= 1'b0;
        end else begin
            ring_d1_q <= ring_s;
        end
    end
    assign ring_tick = ring_s && !ring_d1_q;

    // a single low sample is a dip and is filtered out
    always_ff @(posedge clk_i) begin
        if (srst_i || !mon_en_o) begin
            rst_lo_q  <= 2'h0;
            warn_lo_q <= 2'h0;
        end else if (ring_tick) begin
            rst_lo_q  <= rst_ok_s ? 2'h0 : (rst_lo_q == sfrs_pkg::FILT_TICKS ?
                                            rst_lo_q : rst_lo_q + 2'h1);
            warn_lo_q <= warn_ok_s ? 2'h0 : (warn_lo_q == sfrs_pkg::FILT_TICKS ?
                                             warn_lo_q : warn_lo_q + 2'h1);
        end
    end
    assign rst_fail  = (rst_lo_q == sfrs_pkg::FILT_TICKS);
    assign warn_fail = (warn_lo_q == sfrs_pkg::FILT_TICKS);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            sfrs_pkg::ST_OFF: begin
                state_d = sfrs_pkg::ST_PFRST;
            end
            sfrs_pkg::ST_PFRST: begin
                if (tmr_zero) state_d = sfrs_pkg::ST_CHECK;
            end
            sfrs_pkg::ST_CHECK: begin
                if (ring_tick && rst_ok_s && chk_cnt_q == sfrs_pkg::CHK_LAST) begin
                    state_d = sfrs_pkg::ST_SETTLE;
                end else if (ring_tick && !rst_ok_s && (chk_cnt_q != 2'h0 || chk_win_q)) begin
                    state_d = sfrs_pkg::ST_PFRST;
                end
            end
            sfrs_pkg::ST_SETTLE: begin
                if (tmr_zero) state_d = sfrs_pkg::ST_RUN;
            end
            sfrs_pkg::ST_RUN: begin
                if (ext_rst_i) state_d = sfrs_pkg::ST_EXTRST;
                else if (rst_fail) state_d = sfrs_pkg::ST_PFRST;
                else if (stop_req_i && rst_ok_s) state_d = sfrs_pkg::ST_STOP;
            end
            sfrs_pkg::ST_EXTRST: begin
                if (rst_fail) state_d = sfrs_pkg::ST_PFRST;
                else if (!ext_rst_i && tmr_zero) state_d = sfrs_pkg::ST_RUN;
            end
            sfrs_pkg::ST_STOP: begin
                if (wake_q && ring_tick) begin
                    state_d = rst_ok_s ? sfrs_pkg::ST_SETTLE : sfrs_pkg::ST_PFRST;
                end else if (!monoff_q && rst_fail) begin
                    state_d = sfrs_pkg::ST_PFRST;
                end else if (!monoff_q && warn_fail) begin
                    state_d = sfrs_pkg::ST_SETTLE;
                end
            end
            default: state_d = sfrs_pkg::ST_OFF;
        endcase
        if (!por_ok_s) state_d = sfrs_pkg::ST_OFF;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_q <= sfrs_pkg::ST_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // one timer serves the pf-reset, settle and pin-reset states; reloaded on entry and while pin reset holds
    assign enter    = (state_d != state_q);
    assign tmr_load = enter || (state_q == sfrs_pkg::ST_EXTRST && ext_rst_i);
    assign tmr_val  = (state_d == sfrs_pkg::ST_PFRST)  ? ivl_ticks(ivl_q) :
                      (state_d == sfrs_pkg::ST_SETTLE) ? SETTLE_CYC : sfrs_pkg::EXT_REL_CYC;
    assign tmr_tick = (state_q == sfrs_pkg::ST_PFRST) ? ring_tick : 1'b1;

    sfrs_timer u_tmr (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .load_i (tmr_load),
        .value_i(tmr_val),
        .tick_i (tmr_tick),
        .zero_o (tmr_zero)
    );

    always_ff @(posedge clk_i) begin
        if (srst_i || (enter && state_d == sfrs_pkg::ST_CHECK)) begin
            chk_cnt_q <= 2'h0;
            chk_win_q <= 1'b0;
        end else if (state_q == sfrs_pkg::ST_CHECK && ring_tick) begin
            if (rst_ok_s) chk_cnt_q <= chk_cnt_q + 2'h1;
            else chk_win_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wake_q      <= 1'b0;
            wake_prio_q <= 4'h0;
        end else if (state_q != sfrs_pkg::ST_STOP) begin
            wake_q      <= 1'b0;
            wake_prio_q <= 4'h0;
        end else if (wake_irq_i && !wake_q) begin
            wake_q      <= 1'b1;
            wake_prio_q <= wake_prio_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wake_exit_q <= 1'b0;
            pf_boot_q   <= 1'b1;
            take_warn_q <= 1'b0;
            stop_exit_q <= 1'b0;
            boot_q      <= sfrs_pkg::RESET_VEC;
        end else begin
            stop_exit_q <= 1'b0;
            if (enter && state_d == sfrs_pkg::ST_PFRST) begin
                pf_boot_q   <= 1'b1;
                wake_exit_q <= 1'b0; // a cut stop exit must not skip the cpu reset later
            end
            if (enter && state_d == sfrs_pkg::ST_EXTRST) pf_boot_q <= 1'b0;
            if (state_q == sfrs_pkg::ST_STOP && state_d == sfrs_pkg::ST_SETTLE) begin
                wake_exit_q <= 1'b1;
                take_warn_q <= warn_set && (warn_prio_q >= wake_prio_q);
            end
            if (state_d == sfrs_pkg::ST_RUN && enter) begin
                wake_exit_q <= 1'b0;
                stop_exit_q <= wake_exit_q;
                if (!wake_exit_q) begin
                    boot_q    <= pf_boot_q ? sfrs_pkg::UROM_VEC : sfrs_pkg::RESET_VEC;
                    pf_boot_q <= 1'b0;
                end
            end
        end
    end

    // warning in run, or found at a stop exit before the supplies restart
    assign warn_set = (state_q == sfrs_pkg::ST_RUN && warn_fail) ||
                      (state_q == sfrs_pkg::ST_STOP && state_d == sfrs_pkg::ST_SETTLE &&
                       (warn_fail || !warn_ok_s));
    assign pfr_set  = enter && state_d == sfrs_pkg::ST_PFRST;

    assign apb_wr   = psel && penable && pwrite;
    assign ctrl_hit = (paddr == sfrs_pkg::CTRL_OFF);
    assign stat_hit = (paddr == sfrs_pkg::STAT_OFF);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            monoff_q    <= sfrs_pkg::MONOFF_RST;
            ivl_q       <= sfrs_pkg::IVL_RST;
            warn_prio_q <= sfrs_pkg::PRIO_RST;
        end else if (apb_wr && ctrl_hit) begin
            monoff_q    <= pwdata[sfrs_pkg::CTRL_MONOFF_BIT];
            ivl_q       <= pwdata[sfrs_pkg::CTRL_IVL_LSB +: 2];
            warn_prio_q <= pwdata[sfrs_pkg::CTRL_PRIO_LSB +: 4];
        end
    end

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            warn_flag_q <= 1'b0;
            pfr_flag_q  <= 1'b0;
        end else begin
            warn_flag_q <= warn_set || (warn_flag_q &&
                           !(apb_wr && stat_hit && pwdata[sfrs_pkg::STAT_WARN_BIT]));
            pfr_flag_q  <= pfr_set || (pfr_flag_q &&
                           !(apb_wr && stat_hit && pwdata[sfrs_pkg::STAT_PFR_BIT]));
        end
    end

    // read data prepared in the setup phase so the access needs no wait
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            prdata_q <= 32'h0;
        end else if (psel && !penable) begin
            prdata_q <= 32'h0;
            if (ctrl_hit) begin
                prdata_q[sfrs_pkg::CTRL_MONOFF_BIT]   <= monoff_q;
                prdata_q[sfrs_pkg::CTRL_IVL_LSB +: 2]  <= ivl_q;
                prdata_q[sfrs_pkg::CTRL_PRIO_LSB +: 4] <= warn_prio_q;
            end else if (stat_hit) begin
                prdata_q[sfrs_pkg::STAT_WARN_BIT]       <= warn_flag_q;
                prdata_q[sfrs_pkg::STAT_PFR_BIT]        <= pfr_flag_q;
                prdata_q[sfrs_pkg::STAT_STATE_LSB +: 3] <= state_q;
                prdata_q[sfrs_pkg::STAT_RST_OK_BIT]     <= rst_ok_s;
                prdata_q[sfrs_pkg::STAT_WARN_OK_BIT]    <= warn_ok_s;
            end
        end
    end

    assign prdata  = prdata_q;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !(ctrl_hit || stat_hit);

    assign cpu_rst_o  = (state_q == sfrs_pkg::ST_OFF) || (state_q == sfrs_pkg::ST_PFRST) ||
                        (state_q == sfrs_pkg::ST_CHECK) || (state_q == sfrs_pkg::ST_EXTRST) ||
                        (state_q == sfrs_pkg::ST_SETTLE && !wake_exit_q);
    assign reg_en_o   = (state_q == sfrs_pkg::ST_SETTLE) || (state_q == sfrs_pkg::ST_RUN) ||
                        (state_q == sfrs_pkg::ST_EXTRST);
    assign osc_en_o   = reg_en_o;
    assign mon_en_o   = reg_en_o || (state_q == sfrs_pkg::ST_CHECK) ||
                        (state_q == sfrs_pkg::ST_PFRST && ivl_q == 2'h0) ||
                        (state_q == sfrs_pkg::ST_STOP && (!monoff_q || wake_q));
    assign sram_ret_o = (state_q != sfrs_pkg::ST_OFF);
    assign stop_exit_o = stop_exit_q;
    assign take_warn_o = take_warn_q;
    assign supply_warn_irq_flag_o = warn_flag_q;
    assign boot_addr_o = boot_q;

    // helper: cycles spent in the settle state
    logic [23:0] settle_cyc_q;
    always_ff @(posedge clk_i) begin
        if (srst_i || state_q != sfrs_pkg::ST_SETTLE) settle_cyc_q <= 24'h0;
        else settle_cyc_q <= settle_cyc_q + 24'h1;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    check_extend_a: assert property (state_q == sfrs_pkg::ST_CHECK && ring_tick && rst_ok_s &&
        chk_cnt_q == 2'h0 && por_ok_s |=> state_q == sfrs_pkg::ST_CHECK)
        else $error("check ended early");
    third_ok_a: assert property (state_q == sfrs_pkg::ST_CHECK && state_d == sfrs_pkg::ST_SETTLE
        |-> chk_cnt_q == 2'h2 && rst_ok_s)
        else $error("release before third period");
    settle_wait_a: assert property (state_q == sfrs_pkg::ST_SETTLE &&
        state_d == sfrs_pkg::ST_RUN |-> settle_cyc_q >= SETTLE_CYC - 24'h1)
        else $error("settle too short");
    rom_boot_a: assert property (state_q == sfrs_pkg::ST_SETTLE && state_d == sfrs_pkg::ST_RUN &&
        pf_boot_q && !wake_exit_q |=> boot_addr_o == 16'h8000)
        else $error("wrong boot address");
    ext_keep_a: assert property (state_q == sfrs_pkg::ST_EXTRST |->
        reg_en_o && osc_en_o && mon_en_o && cpu_rst_o)
        else $error("supplies off in pin reset");
    ext_fast_a: assert property (state_q == sfrs_pkg::ST_EXTRST && !ext_rst_i ##1
        (!ext_rst_i)[*3] |-> ##[0:15] !cpu_rst_o || state_q != sfrs_pkg::ST_EXTRST)
        else $error("slow release");
    stop_off_a: assert property (state_q == sfrs_pkg::ST_STOP |-> !reg_en_o && !osc_en_o &&
        sram_ret_o && mon_en_o == (!monoff_q || wake_q))
        else $error("stop supplies wrong");
    dip_ignore_a: assert property (state_q == sfrs_pkg::ST_RUN && ring_tick && !rst_ok_s &&
        rst_lo_q == 2'h0 && !ext_rst_i |=> state_q != sfrs_pkg::ST_PFRST)
        else $error("dip caused reset");
    run_fail_a: assert property (state_q == sfrs_pkg::ST_RUN && rst_fail && !ext_rst_i &&
        por_ok_s |=> state_q == sfrs_pkg::ST_PFRST && cpu_rst_o && !reg_en_o)
        else $error("no reset on supply fail");
    off_all_a: assert property (!por_ok_s |=> state_q == sfrs_pkg::ST_OFF && cpu_rst_o &&
        !reg_en_o && !mon_en_o)
        else $error("not off below por");
    wake_flag_a: assert property (state_q == sfrs_pkg::ST_STOP && state_d == sfrs_pkg::ST_SETTLE
        && !warn_ok_s |-> !reg_en_o ##1 (warn_flag_q && reg_en_o))
        else $error("flag not set before restart");
    wake_fail_a: assert property (state_q == sfrs_pkg::ST_STOP && wake_q && ring_tick &&
        !rst_ok_s && por_ok_s |=> state_q == sfrs_pkg::ST_PFRST && cpu_rst_o)
        else $error("no reset at wake");

    pf_recover_c: cover property (state_q == sfrs_pkg::ST_SETTLE && state_d == sfrs_pkg::ST_RUN
        && pf_boot_q);
    stop_wake_c: cover property (stop_exit_o && take_warn_o);
    ext_reset_c: cover property (state_q == sfrs_pkg::ST_EXTRST ##1 state_q == sfrs_pkg::ST_RUN);
endmodule
`default_nettype wire

// ---- hw/sfrs_pkg.sv ----
// shared constants and types of the supply-fail reset sequencer
`default_nettype none
package sfrs_pkg;
    localparam int unsigned CLK_MHZ            = 100;
    localparam int unsigned OSC_SETTLE_US_DFLT = 100;
    localparam int unsigned TMR_W              = 24;
    localparam logic [23:0] EXT_REL_CYC        = 24'h000004;
    localparam logic [1:0]  FILT_TICKS         = 2'h2;
    localparam logic [1:0]  CHK_LAST           = 2'h2;
    localparam logic [23:0] IVL_CONT           = 24'h000001;
    localparam logic [23:0] IVL_2E11           = 24'h000800;
    localparam logic [23:0] IVL_2E12           = 24'h001000;
    localparam logic [23:0] IVL_2E13           = 24'h002000;
    localparam logic [15:0] UROM_VEC           = 16'h8000;
    localparam logic [15:0] RESET_VEC          = 16'h0000;
    localparam logic [11:0] CTRL_OFF           = 12'h000;
    localparam logic [11:0] STAT_OFF           = 12'h004;
    localparam int          CTRL_MONOFF_BIT    = 0;
    localparam int          CTRL_IVL_LSB       = 1;
    localparam int          CTRL_PRIO_LSB      = 4;
    localparam int          STAT_WARN_BIT      = 0;
    localparam int          STAT_PFR_BIT       = 1;
    localparam int          STAT_STATE_LSB     = 4;
    localparam int          STAT_RST_OK_BIT    = 8;
    localparam int          STAT_WARN_OK_BIT   = 9;
    localparam logic        MONOFF_RST         = 1'b1;
    localparam logic [1:0]  IVL_RST            = 2'h0;
    localparam logic [3:0]  PRIO_RST           = 4'h0;
    typedef enum logic [2:0] {
        ST_OFF    = 3'h0,
        ST_PFRST  = 3'h1,
        ST_CHECK  = 3'h3,
        ST_SETTLE = 3'h2,
        ST_RUN    = 3'h6,
        ST_STOP   = 3'h7,
        ST_EXTRST = 3'h4
    } sfrs_state_e;
endpackage
`default_nettype wire

// ---- hw/sfrs_sync.sv ----
// two-flop synchroniser for a group of asynchronous levels
`default_nettype none
module sfrs_sync #(
    parameter int W = 4
) (
    input  wire logic         clk_i,
    input  wire logic         srst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk_i) begin
            if (srst_i) begin
                meta_q[i] <= 1'b0;
                sync_q[i] <= 1'b0;
            end else begin
                meta_q[i] <= d_i[i];
                sync_q[i] <= meta_q[i];
            end
        end
    end

    assign q_o = sync_q;
endmodule
`default_nettype wire

// ---- hw/sfrs_timer.sv ----
// loadable down counter used for settle, release and sleep intervals
`default_nettype none
module sfrs_timer (
    input  wire logic                       clk_i,
    input  wire logic                       srst_i,
    input  wire logic                       load_i,
    input  wire logic [sfrs_pkg::TMR_W-1:0] value_i,
    input  wire logic                       tick_i,
    output logic                            zero_o
);
    logic [sfrs_pkg::TMR_W-1:0] cnt_q;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cnt_q <= '0;
        end else if (load_i) begin
            cnt_q <= value_i;
        end else if (tick_i && cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign zero_o = (cnt_q == '0);
endmodule
`default_nettype wire

// ---- verif/sfrs_supply_model.sv ----
// supply comparators and ring oscillator model facing the sequencer
`default_nettype none
module sfrs_supply_model (
    input  wire logic [1:0] lvl_i,
    output logic            ring_clk_o,
    output logic            por_ok_o,
    output logic            rst_ok_o,
    output logic            warn_ok_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ring runs free, 20 clk periods, phase unrelated to clk_i; faster than silicon for short runs
    initial begin
        ring_clk_o = 1'b0;
        #37;
        forever #100 ring_clk_o = ~ring_clk_o;
    end
    // lvl: 0 below power-on, 1 below trip, 2 below warning, 3 good
    assign por_ok_o  = (lvl_i != 2'h0);
    assign rst_ok_o  = (lvl_i > 2'h1);
    assign warn_ok_o = (lvl_i == 2'h3);
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// testbench for the supply-fail reset sequencer
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int RP = 20;
    logic        clk_i, srst_i, ring, por_ok, rst_ok, warn_ok;
    logic [1:0]  lvl;
    logic        ext_rst, stop_req, wake_irq, psel, penable, pwrite, pready, pslverr, err;
    logic [3:0]  wake_prio;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        cpu_rst, reg_en, osc_en, mon_en, sram_ret, stop_exit, take_warn, flag;
    logic [15:0] boot;
    int          num_errors, comparisons, n;

    sfrs_supply_model i_model (.lvl_i(lvl), .ring_clk_o(ring), .por_ok_o(por_ok),
        .rst_ok_o(rst_ok), .warn_ok_o(warn_ok));
    sfrs_top #(.OSC_SETTLE_US(1)) i_dut (.clk_i(clk_i), .srst_i(srst_i), .por_ok_i(por_ok),
        .rst_ok_i(rst_ok), .warn_ok_i(warn_ok), .ring_clk_i(ring), .ext_rst_i(ext_rst),
        .stop_req_i(stop_req), .wake_irq_i(wake_irq), .wake_prio_i(wake_prio), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cpu_rst_o(cpu_rst), .reg_en_o(reg_en),
        .osc_en_o(osc_en), .mon_en_o(mon_en), .sram_ret_o(sram_ret), .stop_exit_o(stop_exit),
        .take_warn_o(take_warn), .supply_warn_irq_flag_o(flag), .boot_addr_o(boot));

    always #5 clk_i = ~clk_i;

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_i);
        penable <= 1'b1;
        do @(posedge clk_i); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // sel 0 waits on cpu reset, 1 on the stop-exit pulse; n counts edges
    task waitv(input int sel, input logic v, input int lim);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (((sel == 0) ? cpu_rst : stop_exit) !== v && n < lim);
        if (n >= lim) begin
            num_errors++;
            $display("FAIL t=%0t wait ran out", $time);
        end
    endtask

    task ticks(input int k);
        repeat (k * RP) @(posedge clk_i);
    endtask

    task pulse_stop;
        @(posedge clk_i);
        stop_req <= 1'b1;
        @(posedge clk_i);
        stop_req <= 1'b0;
    endtask

    // supply good again: three good ring periods plus 100 settle cycles before release
    task recover(input int lim, input int least);
        @(posedge clk_i);
        lvl <= 2'h3;
        waitv(0, 1'b0, lim);
        chk(n >= least, 1'b1);
        chk(boot, sfrs_pkg::UROM_VEC);
    endtask

    task stop_wake(input logic [3:0] wp, input logic [3:0] wk, input logic exp);
        apb(1'b1, sfrs_pkg::CTRL_OFF, {24'h0, wp, 4'h1});
        pulse_stop;
        ticks(2);
        lvl <= 2'h2;
        ticks(4);
        chk({reg_en, osc_en, mon_en, flag}, 4'h0);
        wake_prio <= wk;
        wake_irq <= 1'b1;
        @(posedge clk_i);
        wake_irq <= 1'b0;
        waitv(1, 1'b1, 20 * RP);
        chk(flag, 1'b1);
        chk(take_warn, exp);
        lvl <= 2'h3;
        ticks(3);
        apb(1'b1, sfrs_pkg::STAT_OFF, 32'h3);
    endtask

    task test_done;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk_i);
        num_errors++;
        $display("FAIL t=%0t watchdog", $time);
        test_done;
    end

    initial begin
        {clk_i, ext_rst, stop_req, wake_irq, psel, penable, pwrite} = '0;
        {wake_prio, paddr, pwdata, lvl, num_errors, comparisons} = '0;
        srst_i = 1'b1;
        repeat (8) @(posedge clk_i);
        srst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk({cpu_rst, reg_en, osc_en, mon_en}, 4'h8);
        apb(1'b0, sfrs_pkg::CTRL_OFF, 32'h0);
        chk(rd[0], 1'b1);
        apb(1'b0, 12'h008, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        recover(1000, 100 + 2 * RP);
        // pin reset: supplies stay on, quick release with the plain vector
        ext_rst <= 1'b1;
        repeat (5) @(posedge clk_i);
        chk({cpu_rst, reg_en, osc_en, mon_en}, 4'hf);
        ext_rst <= 1'b0;
        waitv(0, 1'b0, 40);
        chk(n < 20, 1'b1);
        chk(boot, sfrs_pkg::RESET_VEC);
        lvl <= 2'h1;
        repeat (15) @(posedge clk_i);
        lvl <= 2'h3;
        ticks(3);
        chk({cpu_rst, flag}, 2'h0);
        lvl <= 2'h2;
        ticks(4);
        chk({cpu_rst, flag}, 2'h1);
        lvl <= 2'h3;
        ticks(2);
        apb(1'b1, sfrs_pkg::STAT_OFF, 32'h1);
        apb(1'b0, sfrs_pkg::STAT_OFF, 32'h0);
        chk(rd[0], 1'b0);
        apb(1'b1, sfrs_pkg::CTRL_OFF, 32'h0);
        pulse_stop;
        ticks(1);
        chk({reg_en, osc_en, sram_ret, mon_en}, 4'h3);
        lvl <= 2'h2;
        waitv(1, 1'b1, 20 * RP);
        chk({reg_en, osc_en, cpu_rst, take_warn}, 4'hd);
        lvl <= 2'h3;
        ticks(3);
        apb(1'b1, sfrs_pkg::STAT_OFF, 32'h3);
        stop_wake(4'h5, 4'h3, 1'b1);
        stop_wake(4'h2, 4'h9, 1'b0);
        stop_wake(4'h7, 4'h7, 1'b1);
        // monitor off in stop, periodic interval of 2^11 ring clocks after the fail
        apb(1'b1, sfrs_pkg::CTRL_OFF, 32'h3);
        pulse_stop;
        ticks(2);
        lvl <= 2'h1;
        ticks(1);
        wake_irq <= 1'b1;
        @(posedge clk_i);
        wake_irq <= 1'b0;
        waitv(0, 1'b1, 10 * RP);
        ticks(6);
        apb(1'b0, sfrs_pkg::STAT_OFF, 32'h0);
        chk({cpu_rst, rd[1], mon_en}, 3'h6);
        lvl <= 2'h0;
        ticks(1);
        chk({cpu_rst, reg_en, osc_en, mon_en}, 4'h8);
        recover(45000, (2 ** 11 - 1) * RP + 100);
        test_done;
    end
endmodule
`default_nettype wire
